// >>> design/adc_pwr_pkg.sv
package adc_pwr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame geometry, counted in serial clock falling edges after the frame opens
  localparam int unsigned CNT_W         = 6;
  localparam int unsigned RES_W         = 12;
  localparam logic [5:0]  EDGE_GLITCH   = 6'h02;  // Edges needed before a rise can power down
  localparam logic [5:0]  EDGE_KEEP     = 6'h0A;  // Edges needed to stay or become powered
  localparam logic [5:0]  EDGE_TRACK    = 6'h0D;  // Sample is released after this edge
  localparam logic [5:0]  EDGE_RESULT   = 6'h0E;  // One complete result has been shifted
  localparam logic [5:0]  EDGE_LAST     = 6'h20;  // Lines float here; counter saturates
  localparam logic [5:0]  FIRST_MSB_POS = 6'h02;  // Edge count showing MSB of first word
  localparam logic [5:0]  FIRST_LSB_POS = 6'h0D;
  localparam logic [5:0]  SECOND_MSB_POS = 6'h12; // Edge count showing MSB of second word
  localparam logic [5:0]  SECOND_LSB_POS = 6'h1D;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing on ref_clk
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned WAKE_PARTIAL_NS = 1000;
  localparam int unsigned WAKE_FULL_NS    = 1500000;  // deep_sleep_wake_time
  localparam int unsigned DWELL_NS        = 67000;
  // Least times, rounded up to whole cycles
  localparam int unsigned WAKE_PARTIAL_CYC =
    (WAKE_PARTIAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_FULL_CYC    = (WAKE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DWELL_CYC        = (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W          = 19;
  localparam int unsigned SYNC_W           = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST   = 4'h8;  // Chip select idles high

  ////////////////////////////////////////////////////////////////////////////////
  // Power states
  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_PARTIAL,
    PWR_FULL
  } pwr_state_t;

endpackage

// >>> design/pin_sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser; an output bit changes once stages two and three agree
module pin_sync3 #(
  parameter int unsigned            W       = 4,
  parameter logic [W-1:0]           RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous inputs and filtered result
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // First stage feeds only the second; agreement of two and three qualifies a change
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.q;

endmodule

// >>> design/adc_power_mode_sequencer.sv
`timescale 1ns/1ps
// What this block does
// [RULE1] Chip select fall starts sampling, a conversion and a fresh edge count.
// [RULE2] Host holds chip select low past ten edges to stay fully powered.
// [RULE3] Rise between tenth and fourteenth edge: stay powered, abandon, float both lines.
// [RULE4] Fourteen cycles give one result; line stays driven until chip select rises.
// [RULE5] Two more cycles low shift out two trailing zeros.
// [RULE6] A further fourteen or sixteen cycles deliver the other converter's result.
// [RULE7] Active line floats on the thirty-second edge or an earlier rise.
// [RULE8] Host waits the idle time and acquisition time before the next frame.
// [RULE9] From normal, rise between second and tenth edge enters partial power-down.
// [RULE10] From normal, rise before the second edge keeps normal mode.
// [RULE11] Partial power-down keeps only the reference and its buffer on.
// [RULE12] Dummy frame past ten edges wakes partial power-down after about 1 us.
// [RULE13] In partial power-down, rise before second edge returns there, undoing power-up.
// [RULE14] In partial power-down, rise between second and tenth edge enters full power-down.
// [RULE15] Host need not finish fourteen clocks after an early rise.
// [RULE16] Full power-down wake: dummy frame, then about 1.5 ms before converting.
// [RULE17] Short partial wake needs 67 us spent in partial power-down first.
// [RULE18] After supply-up the host runs one dummy frame before trusting data.
// [RULE19] Two dummy frames after supply-up reach partial power-down.
// [RULE20] Three dummy frames after supply-up reach full power-down.
// [RULE21] Chip select fall drives the result lines and holds the input sample.
// [RULE22] Each result: two leading zeros then twelve bits, MSB first.
// [RULE23] A serial clock fall coinciding with chip select fall is not counted.
// [RULE24] Power state is three-valued, updated only at chip select rises.
// [RULE25] Edge counter saturates at thirty-two and clears at each frame start.
module adc_power_mode_sequencer
  import adc_pwr_pkg::*;
#(
  parameter int unsigned WAKE_FULL_CYCLES = WAKE_FULL_CYC,
  parameter int unsigned DWELL_CYCLES     = DWELL_CYC
) (
  // System clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Serial link from the host
  input  wire logic             serial_clk,
  input  wire logic             chip_sel_n,
  // Result lines, three-state
  output logic                  result_line_first,
  output logic                  result_line_first_oe,
  output logic                  result_line_second,
  output logic                  result_line_second_oe,
  // Converter core, on serial_clk
  input  wire logic [RES_W-1:0] sar_result_a,
  input  wire logic [RES_W-1:0] sar_result_b,
  output logic                  hold_sample,
  // Power control, on ref_clk
  output pwr_state_t            pwr_state,
  output logic                  analog_en,
  output logic                  ref_en,
  output logic                  wake_done,
  output logic                  frame_aborted,
  output logic                  frame_complete
);

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain state: link_r cleared while chip select is high, milestone flags by the power logic

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             bit_first;
    logic             bit_second;
    logic             tracking;
  } link_t;

  typedef struct packed {
    logic reach_glitch;
    logic reach_keep;
    logic reach_result;
  } mark_t;

  link_t link_r;
  link_t link_nxt;
  mark_t mark_r;
  mark_t mark_nxt;

  // Picks the word bit shown at a given edge count, MSB first
  function automatic logic pick_bit(input logic [RES_W-1:0] word,
                                    input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] msb_pos);
    logic [CNT_W-1:0] off;
    off = cnt - msb_pos;
    return word[4'(RES_W - 1) - off[3:0]];
  endfunction

  // Serial bit for an edge count; zeros fill leading, trailing and idle slots
  function automatic logic serial_bit(input logic [RES_W-1:0] own_word,
                                      input logic [RES_W-1:0] other_word,
                                      input logic [CNT_W-1:0] cnt);
    logic b;
    b = 1'b0;
    // [RULE22] zeros then MSB first
    if (cnt >= FIRST_MSB_POS && cnt <= FIRST_LSB_POS) begin
      b = pick_bit(own_word, cnt, FIRST_MSB_POS);
    // [RULE6] other converter follows
    end else if (cnt >= SECOND_MSB_POS && cnt <= SECOND_LSB_POS) begin
      b = pick_bit(other_word, cnt, SECOND_MSB_POS);
    end
    return b;
  endfunction

  // Next link state, taken on each serial clock falling edge
  always_comb begin
    link_nxt = link_r;
    // [RULE25] saturate at the last edge
    if (link_r.cnt != EDGE_LAST) begin
      link_nxt.cnt = link_r.cnt + 6'h01;
    end
    // [RULE5] trailing zeros fall out of the default slot value
    link_nxt.bit_first  = serial_bit(sar_result_a, sar_result_b, link_nxt.cnt);
    link_nxt.bit_second = serial_bit(sar_result_b, sar_result_a, link_nxt.cnt);
    if (link_nxt.cnt >= EDGE_TRACK) begin
      link_nxt.tracking = 1'b1;
    end
  end

  // [RULE1] chip select high holds the count at zero; its fall opens the frame.
  // [RULE23] an edge coincident with the fall still sees reset and is not counted.
  always_ff @(negedge serial_clk or posedge chip_sel_n) begin
    if (chip_sel_n) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  // Milestone flags survive the chip select rise so the power logic can read them
  always_comb begin
    mark_nxt = mark_r;
    if (link_nxt.cnt >= EDGE_GLITCH) begin
      mark_nxt.reach_glitch = 1'b1;
    end
    if (link_nxt.cnt >= EDGE_KEEP) begin
      mark_nxt.reach_keep = 1'b1;
    end
    if (link_nxt.cnt >= EDGE_RESULT) begin
      mark_nxt.reach_result = 1'b1;
    end
  end

  logic mark_clr_r;

  // Cleared by the power logic once it has taken the frame's outcome
  always_ff @(negedge serial_clk or posedge mark_clr_r) begin
    if (mark_clr_r) begin
      mark_r <= '0;
    end else begin
      mark_r <= mark_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result line drive

  // [RULE21] drive from the fall; first leading zero is the reset value
  // [RULE4] stays driven after fourteen edges
  // [RULE7] floats at the last edge or at the rise
  // [RULE3] an early rise floats both lines at once
  assign result_line_first_oe  = !chip_sel_n && (link_r.cnt != EDGE_LAST);
  assign result_line_second_oe = !chip_sel_n && (link_r.cnt != EDGE_LAST);
  assign result_line_first     = link_r.bit_first;
  assign result_line_second    = link_r.bit_second;

  // [RULE21] sample held from the fall until the track point
  assign hold_sample = !chip_sel_n && !link_r.tracking;

  ////////////////////////////////////////////////////////////////////////////////
  // Crossing into ref_clk: chip select and the frame milestones

  logic [SYNC_W-1:0] sync_q;
  logic              cs_n_s;
  logic              glitch_s;
  logic              keep_s;
  logic              result_s;

  pin_sync3 #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk      (ref_clk),
    .rst      (sys_rst),
    .async_in ({chip_sel_n, mark_r.reach_result, mark_r.reach_keep, mark_r.reach_glitch}),
    .sync_out (sync_q)
  );

  assign cs_n_s   = sync_q[3];
  assign result_s = sync_q[2];
  assign keep_s   = sync_q[1];
  assign glitch_s = sync_q[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Power state machine on ref_clk

  typedef struct packed {
    pwr_state_t         pwr;
    logic               cs_n_q;
    logic               clr;
    logic               waking;
    logic [TIMER_W-1:0] wake_cnt;
    logic [TIMER_W-1:0] dwell_cnt;
    logic               dwell_ok;
    logic               aborted;
    logic               complete;
  } pwr_t;

  pwr_t pwr_r;
  pwr_t pwr_nxt;

  logic frame_open;
  logic frame_close;

  assign frame_open  = pwr_r.cs_n_q && !cs_n_s;
  assign frame_close = !pwr_r.cs_n_q && cs_n_s;

  always_comb begin
    pwr_nxt         = pwr_r;
    pwr_nxt.cs_n_q  = cs_n_s;
    pwr_nxt.aborted = 1'b0;

    // Release the milestone clear once the flags read back empty; a new frame
    // must not open until then, which the idle time between frames covers
    if (pwr_r.clr && !glitch_s && !keep_s && !result_s) begin
      pwr_nxt.clr = 1'b0;
    end

    // [RULE17] time spent in partial power-down decides the short wake
    if (pwr_r.pwr == PWR_PARTIAL) begin
      if (pwr_r.dwell_cnt >= TIMER_W'(DWELL_CYCLES - 1)) begin
        pwr_nxt.dwell_ok = 1'b1;
      end else begin
        pwr_nxt.dwell_cnt = pwr_r.dwell_cnt + 19'h00001;
      end
    end else begin
      pwr_nxt.dwell_cnt = '0;
      pwr_nxt.dwell_ok  = 1'b0;
    end

    // Wake timer counts down from the frame start
    if (pwr_r.waking && pwr_r.wake_cnt != '0) begin
      pwr_nxt.wake_cnt = pwr_r.wake_cnt - 19'h00001;
    end
    if (pwr_r.waking && pwr_r.wake_cnt == '0) begin
      pwr_nxt.waking = 1'b0;
    end

    // [RULE12] [RULE16] a frame opened from power-down starts the wake timer
    if (frame_open) begin
      pwr_nxt.complete = 1'b0;
      if (pwr_r.pwr == PWR_PARTIAL && pwr_r.dwell_ok) begin
        pwr_nxt.waking   = 1'b1;
        pwr_nxt.wake_cnt = TIMER_W'(WAKE_PARTIAL_CYC - 1);
      end else if (pwr_r.pwr != PWR_NORMAL) begin
        // Too short a partial stay is treated like full power-down
        pwr_nxt.waking   = 1'b1;
        pwr_nxt.wake_cnt = TIMER_W'(WAKE_FULL_CYCLES - 1);
      end
    end

    // [RULE24] the power state moves only at the chip select rise
    if (frame_close) begin
      pwr_nxt.clr      = 1'b1;
      pwr_nxt.complete = result_s;
      if (keep_s) begin
        // [RULE3] past ten edges: powered; short of a result it is abandoned
        pwr_nxt.pwr     = PWR_NORMAL;
        pwr_nxt.aborted = !result_s;
      end else if (glitch_s) begin
        pwr_nxt.aborted = 1'b1;
        pwr_nxt.waking  = 1'b0;
        unique case (pwr_r.pwr)
          // [RULE9] normal to partial
          PWR_NORMAL:  pwr_nxt.pwr = PWR_PARTIAL;
          // [RULE14] partial to full
          PWR_PARTIAL: pwr_nxt.pwr = PWR_FULL;
          PWR_FULL:    pwr_nxt.pwr = PWR_FULL;
          default:     pwr_nxt.pwr = PWR_FULL;
        endcase
      end else begin
        // [RULE10] [RULE13] too few edges: state kept, power-up undone
        pwr_nxt.waking = 1'b0;
        if (pwr_r.pwr != PWR_NORMAL) begin
          pwr_nxt.aborted = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_r <= '{pwr: PWR_NORMAL, cs_n_q: 1'b1, clr: 1'b1, waking: 1'b0,
                 wake_cnt: '0, dwell_cnt: '0, dwell_ok: 1'b0, aborted: 1'b0,
                 complete: 1'b0};
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Clear drives an asynchronous reset in the link domain, so it is a flop output
  assign mark_clr_r = pwr_r.clr;

  ////////////////////////////////////////////////////////////////////////////////
  // Power control outputs

  // [RULE11] partial keeps the reference; analog powers up during any frame
  // [RULE13] and drops again at the rise unless the frame passed ten edges
  assign analog_en = (pwr_r.pwr == PWR_NORMAL) || !pwr_r.cs_n_q;
  assign ref_en    = (pwr_r.pwr != PWR_FULL) || !pwr_r.cs_n_q;

  assign pwr_state      = pwr_r.pwr;
  assign wake_done      = (pwr_r.pwr == PWR_NORMAL) && !pwr_r.waking;
  assign frame_aborted  = pwr_r.aborted;
  assign frame_complete = pwr_r.complete;

endmodule

// >>> tb/adc_power_mode_sequencer_chk.sv
`timescale 1ns/1ps
module adc_power_mode_sequencer_chk
  import adc_pwr_pkg::*;
(
  // Clocks and resets
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             serial_clk,
  input  wire logic             chip_sel_n,
  // Result lines and converter words
  input  wire logic             result_line_first,
  input  wire logic             result_line_first_oe,
  input  wire logic             result_line_second,
  input  wire logic             result_line_second_oe,
  input  wire logic [RES_W-1:0] sar_result_a,
  input  wire logic [RES_W-1:0] sar_result_b,
  input  wire logic             hold_sample,
  // Power control
  input  pwr_state_t            pwr_state,
  input  wire logic             analog_en,
  input  wire logic             ref_en,
  input  wire logic             wake_done,
  input  wire logic             frame_aborted
);
  // Own edge count; chip select high clears it, so no stale count leaks into a frame
  logic [CNT_W-1:0] edge_cnt_r;
  always_ff @(negedge serial_clk or posedge chip_sel_n) begin
    if (chip_sel_n) begin
      edge_cnt_r <= '0;
    end else if (edge_cnt_r != EDGE_LAST) begin
      edge_cnt_r <= edge_cnt_r + 6'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // idle lines float
  oe_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    chip_sel_n |-> !result_line_first_oe && !result_line_second_oe)
    else $error("result line driven while deselected");
  oe_count_a: assert property (@(posedge serial_clk) disable iff (chip_sel_n)
    result_line_first_oe == (edge_cnt_r < EDGE_LAST) && result_line_second_oe == (edge_cnt_r < EDGE_LAST))
    else $error("result line enable wrong for edge count");
  pad_zero_a: assert property (@(posedge serial_clk) disable iff (chip_sel_n)
    edge_cnt_r inside {[6'h00:6'h01], [6'h0E:6'h11], [6'h1E:6'h1F]}
    |-> !result_line_first && !result_line_second)
    else $error("padding bit not zero");
  own_word_a: assert property (@(posedge serial_clk) disable iff (chip_sel_n)
    edge_cnt_r inside {[FIRST_MSB_POS:FIRST_LSB_POS]}
    |-> result_line_first == sar_result_a[FIRST_LSB_POS - edge_cnt_r]
     && result_line_second == sar_result_b[FIRST_LSB_POS - edge_cnt_r])
    else $error("first word bit wrong");
  other_word_a: assert property (@(posedge serial_clk) disable iff (chip_sel_n)
    edge_cnt_r inside {[SECOND_MSB_POS:SECOND_LSB_POS]}
    |-> result_line_first == sar_result_b[SECOND_LSB_POS - edge_cnt_r]
     && result_line_second == sar_result_a[SECOND_LSB_POS - edge_cnt_r])
    else $error("second word bit wrong");
  lead_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !chip_sel_n && edge_cnt_r == 6'h00 |-> result_line_first_oe && result_line_second_oe
     && !result_line_first && !result_line_second)
    else $error("leading zero missing at frame start");
  hold_span_a: assert property (@(posedge serial_clk) disable iff (chip_sel_n)
    hold_sample == (edge_cnt_r < EDGE_TRACK))
    else $error("hold span wrong");
  state_still_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !chip_sel_n [*8] |-> $stable(pwr_state))
    else $error("power state moved inside a frame");
  analog_pwr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    chip_sel_n [*8] |-> analog_en == (pwr_state == PWR_NORMAL))
    else $error("analog power wrong for state");
  ref_pwr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    chip_sel_n [*8] |-> ref_en == (pwr_state != PWR_FULL))
    else $error("reference power wrong for state");
  abort_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    frame_aborted |=> !frame_aborted)
    else $error("abort flag longer than one cycle");
  wake_down_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pwr_state != PWR_NORMAL |-> !wake_done)
    else $error("wake flagged while powered down");
endmodule
bind adc_power_mode_sequencer adc_power_mode_sequencer_chk i_chk (.ref_clk, .sys_rst,
  .serial_clk, .chip_sel_n, .result_line_first, .result_line_first_oe, .result_line_second,
  .result_line_second_oe, .sar_result_a, .sar_result_b, .hold_sample, .pwr_state,
  .analog_en, .ref_en, .wake_done, .frame_aborted);

// >>> tb/host_frame_model.sv
`timescale 1ns/1ps
module host_frame_model (
  // Link made by the host
  output logic      serial_clk,
  output logic      chip_sel_n,
  // Result lines read back
  input  wire logic result_line_first,
  input  wire logic result_line_second
);
  // Clock stands high between frames
  initial begin
    serial_clk = 1'b1;
    chip_sel_n = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // frame of n falls
  // Odd lead-in keeps the link phase drifting against ref_clk
  task automatic run_frame(input int n, output logic [30:0] cap_f, output logic [30:0] cap_s);
    int i;
    cap_f = '0;
    cap_s = '0;
    #2.3;
    chip_sel_n <= 1'b0;
    #15;
    for (i = 1; i <= n; i++) begin
      serial_clk <= 1'b0;
      #15;
      serial_clk <= 1'b1;
      if (i < 32) begin
        cap_f = {cap_f[29:0], result_line_first};
        cap_s = {cap_s[29:0], result_line_second};
      end
      #15;
    end
    chip_sel_n <= 1'b1;
    #120;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import adc_pwr_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic serial_clk, chip_sel_n, hold_sample, analog_en, ref_en, wake_done;
  logic frame_aborted, frame_complete, rl_f, rl_f_oe, rl_s, rl_s_oe;
  logic [RES_W-1:0] sar_a = 12'hA5C;
  logic [RES_W-1:0] sar_b = 12'h3F1;
  logic [30:0] cap_f, cap_s;
  pwr_state_t pwr_state;
  int n_mismatch, compares, n_abort;
  // Clock and abort pulse tally
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (frame_aborted === 1'b1) n_abort <= n_abort + 1;
  adc_power_mode_sequencer #(.WAKE_FULL_CYCLES(50), .DWELL_CYCLES(20)) i_adc_power_mode_sequencer (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
    .result_line_first(rl_f), .result_line_first_oe(rl_f_oe), .result_line_second(rl_s),
    .result_line_second_oe(rl_s_oe), .sar_result_a(sar_a), .sar_result_b(sar_b),
    .hold_sample(hold_sample), .pwr_state(pwr_state), .analog_en(analog_en), .ref_en(ref_en),
    .wake_done(wake_done), .frame_aborted(frame_aborted), .frame_complete(frame_complete));
  host_frame_model i_host_frame_model (.serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
    .result_line_first(rl_f), .result_line_second(rl_s));
  //////////////////////////////////////////////////////////////////////////////
  // Compare helpers
  task automatic cmp_vec(input logic [30:0] got, input logic [30:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_state(input pwr_state_t got, input pwr_state_t exp);
    cmp_vec({29'h0, got}, {29'h0, exp});
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_vec({30'h0, got}, {30'h0, exp});
  endtask
  task automatic frame(input int n);
    i_host_frame_model.run_frame(n, cap_f, cap_s);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_full_read;
    int k;
    k = n_abort;
    frame(32);
    cmp_vec(cap_f, {1'b0, sar_a, 4'h0, sar_b, 2'b00});
    cmp_vec(cap_s, {1'b0, sar_b, 4'h0, sar_a, 2'b00});
    cmp_bit(frame_complete, 1'b1);
    cmp_state(pwr_state, PWR_NORMAL);
    cmp_bit(n_abort == k, 1'b1);
  endtask
  task automatic t_glitch(input pwr_state_t st);
    int k;
    k = n_abort;
    frame(1);
    cmp_state(pwr_state, st);
    cmp_bit(frame_complete, 1'b0);
    if (st == PWR_NORMAL) cmp_bit(n_abort == k, 1'b1);
    else cmp_bit(n_abort == k + 1, 1'b1);
  endtask
  task automatic t_down(input int n, input pwr_state_t st);
    int k;
    k = n_abort;
    frame(n);
    cmp_state(pwr_state, st);
    cmp_bit(n_abort == k + 1, 1'b1);
    cmp_bit(analog_en, 1'b0);
    cmp_bit(ref_en, st == PWR_PARTIAL);
  endtask
  task automatic t_wake(input int n, input int bound);
    int i;
    frame(n);
    cmp_state(pwr_state, PWR_NORMAL);
    cmp_bit(frame_complete, n >= 14);
    for (i = 0; i < bound && wake_done !== 1'b1; i++) @(posedge ref_clk);
    cmp_bit(wake_done, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence; frames step from normal to partial to full power-down, then wake back to normal
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    t_full_read();
    t_glitch(PWR_NORMAL);
    t_down(5, PWR_PARTIAL);
    t_glitch(PWR_PARTIAL);
    t_down(9, PWR_FULL);
    t_wake(13, 100);
    t_down(2, PWR_PARTIAL);
    repeat (40) @(posedge ref_clk);
    t_wake(10, 200);
    @(posedge ref_clk);
    sar_a <= 12'h1B7;
    sar_b <= 12'hE48;
    t_full_read();
    close_out();
  end
  // Watchdog well past the longest expected run
  initial begin
    #100us;
    n_mismatch++;
    close_out();
  end
endmodule
